/* File: mcu_bus_defs.vh */
`ifndef MCU_BUS_DEFS_VH
`define MCU_BUS_DEFS_VH
// Command opcodes on the command stream
`define OP_READ 3'h0
`define OP_READ_EXT 3'h1
`define OP_WRITE 3'h2
`define OP_WRITE_EXT 3'h3
`define OP_AUX_SET 3'h4
`define OP_AUX_READ 3'h5
`define OP_WAIT_HIGH 3'h6
`define OP_WAIT_LOW 3'h7
// Aux field positions within the aux byte
`define AUX_ZERO_BIT 0
`define AUX_IRQ_BIT 1
// Phase lengths in bus clocks (normal / stretched)
`define ADDR_SETUP_CLKS 4'h1
`define ALE_CLKS 4'h1
`define ALE_SLOW_CLKS 4'h2
`define WR_SETUP_CLKS 4'h1
`define WR_CLKS 4'h1
`define WR_SLOW_CLKS 4'h6
`define RD_CLKS 4'h1
`define RD_SLOW_CLKS 4'h5
`endif

/* File: aux_pin.v */
`timescale 1ns/100ps
// One auxiliary line with direction, level and suspend pull-down
module aux_pin (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control
  input wire wr_en,
  input wire dir_in,
  input wire val_in,
  input wire pull_opt,
  input wire suspend,
  // Pin
  input wire pin_i,
  output wire pin_o,
  output wire pin_oe,
  output wire pull_low,
  // State
  output reg level_r
);
  reg dir_r;
  reg val_r;
  // Stored direction and output value
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dir_r <= 1'b0;
      val_r <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      if (wr_en)
      begin
        dir_r <= dir_in;
        val_r <= val_in;
      end
      level_r <= pin_i;
    end
  end
  // Drive in output mode, weak pull only in input mode
  assign pin_o = val_r;
  assign pin_oe = dir_r;
  assign pull_low = pull_opt & suspend & ~dir_r;
endmodule // aux_pin

/* File: mcu_host_bus.v */
`timescale 1ns/100ps
// Functional notes
// - Eight muxed lines carry address then data
// - Upper address on eight dedicated outputs
// - Commands set, clear or read aux lines
// - Wait commands stall until irq line level
// - After wait, continue with queued commands
// - Ready low lengthens read or write
// - Sequencing clock driven on a pin
// - Active-low select pulses per access only
// - High latch pulse captures low address
// - Write data stable around write strobe
// - Optional weak pull-down during suspend
// - Four access types; extended sets upper
// - Write phase order, select ends late
// - Ready low: latch 2, write 6
// - Read tristates bus; strobe 1 or 5
`include "mcu_bus_defs.vh"
module mcu_host_bus (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Command stream
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire [7:0] cmd_addr_hi,
  input wire [7:0] cmd_addr_lo,
  input wire [7:0] cmd_data,
  // Result stream
  output reg rsp_valid_r,
  output reg [7:0] rsp_data_r,
  // Configuration and status
  input wire pull_opt,
  input wire suspend,
  // Muxed address and data bus
  input wire [7:0] muxed_addr_data_i,
  output reg [7:0] muxed_addr_data_o_r,
  output reg muxed_addr_data_oe_r,
  output wire muxed_addr_data_pull_low,
  // Upper address and strobes
  output reg [7:0] upper_addr_r,
  output reg ale_r,
  output reg cs_n_r,
  output reg rd_n_r,
  output reg wr_n_r,
  input wire peripheral_ready_in,
  output wire bus_clock_out,
  // Auxiliary lines
  input wire aux_line_zero_i,
  output wire aux_line_zero_o,
  output wire aux_line_zero_oe,
  output wire aux_line_zero_pull_low,
  input wire aux_line_irq_wait_i,
  output wire aux_line_irq_wait_o,
  output wire aux_line_irq_wait_oe,
  output wire aux_line_irq_wait_pull_low
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ALE = 3'h2;
  localparam ST_SETUP = 3'h3;
  localparam ST_STROBE = 3'h4;
  localparam ST_CSEND = 3'h5;
  localparam ST_WAIT = 3'h6;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] cnt_r;
  reg [3:0] cnt_nxt;
  reg [2:0] op_r;
  reg [7:0] data_r;
  reg slow_r;
  reg slow_nxt;
  reg cs_late_r;
  wire lvl_zero;
  wire lvl_irq;
  wire is_write;
  wire take;
  wire aux_wr;

  // Choose phase length from sampled ready
  function [3:0] phase_len;
    input slow;
    input [3:0] fast_len;
    input [3:0] slow_len;
    begin
      phase_len = slow ? slow_len : fast_len;
    end
  endfunction

  // Bus access opcodes have the top opcode bit clear
  function is_bus_op;
    input [2:0] op;
    begin
      is_bus_op = (op[2] == 1'b0);
    end
  endfunction

  // Only the extended accesses move the upper address byte
  function is_ext_op;
    input [2:0] op;
    begin
      is_ext_op = (op == `OP_READ_EXT) || (op == `OP_WRITE_EXT);
    end
  endfunction

  // One step of the phase counter
  function [3:0] count_down;
    input [3:0] cnt;
    begin
      count_down = cnt - 4'h1;
    end
  endfunction

  assign is_write = op_r[1];
  assign cmd_ready = (state_r == ST_IDLE);
  assign take = cmd_valid & cmd_ready;
  assign aux_wr = take & (cmd_op == `OP_AUX_SET);
  assign bus_clock_out = clk;
  // Weak pull on bus lines while they are inputs
  assign muxed_addr_data_pull_low = pull_opt & suspend & ~muxed_addr_data_oe_r;

  // Auxiliary lines: data bits carry values, address bits carry direction
  aux_pin u_aux_zero (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(aux_wr),
    .dir_in(cmd_addr_lo[`AUX_ZERO_BIT]),
    .val_in(cmd_data[`AUX_ZERO_BIT]),
    .pull_opt(pull_opt),
    .suspend(suspend),
    .pin_i(aux_line_zero_i),
    .pin_o(aux_line_zero_o),
    .pin_oe(aux_line_zero_oe),
    .pull_low(aux_line_zero_pull_low),
    .level_r(lvl_zero)
  );
  aux_pin u_aux_irq (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(aux_wr),
    .dir_in(cmd_addr_lo[`AUX_IRQ_BIT]),
    .val_in(cmd_data[`AUX_IRQ_BIT]),
    .pull_opt(pull_opt),
    .suspend(suspend),
    .pin_i(aux_line_irq_wait_i),
    .pin_o(aux_line_irq_wait_o),
    .pin_oe(aux_line_irq_wait_oe),
    .pull_low(aux_line_irq_wait_pull_low),
    .level_r(lvl_irq)
  );

  // Next state and phase counter
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    slow_nxt = slow_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          if (is_bus_op(cmd_op))
          begin
            state_nxt = ST_ADDR;
            cnt_nxt = `ADDR_SETUP_CLKS;
          end
          else if (cmd_op[2:1] == 2'b11)
          begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_ADDR:
      begin
        if (cnt_r == 4'h1)
        begin
          slow_nxt = ~peripheral_ready_in;
          state_nxt = ST_ALE;
          cnt_nxt = phase_len(~peripheral_ready_in, `ALE_CLKS, `ALE_SLOW_CLKS);
        end
        else
          cnt_nxt = count_down(cnt_r);
      end
      ST_ALE:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = is_write ? ST_SETUP : ST_STROBE;
          if (is_write)
            cnt_nxt = `WR_SETUP_CLKS;
          else
            cnt_nxt = phase_len(slow_r | ~peripheral_ready_in, `RD_CLKS, `RD_SLOW_CLKS);
        end
        else
          cnt_nxt = count_down(cnt_r);
      end
      ST_SETUP:
      begin
        if (cnt_r == 4'h1)
        begin
          state_nxt = ST_STROBE;
          cnt_nxt = phase_len(slow_r | ~peripheral_ready_in, `WR_CLKS, `WR_SLOW_CLKS);
        end
        else
          cnt_nxt = count_down(cnt_r);
      end
      ST_STROBE:
      begin
        if (cnt_r == 4'h1)
          state_nxt = ST_CSEND;
        else
          cnt_nxt = count_down(cnt_r);
      end
      ST_CSEND:
        state_nxt = ST_IDLE;
      ST_WAIT:
      begin
        // Low opcode bit clear waits for a high line, set waits for a low one
        if (lvl_irq != op_r[0])
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers and bus outputs
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      slow_r <= 1'b0;
      op_r <= 3'h0;
      data_r <= 8'h00;
      upper_addr_r <= 8'h00;
      muxed_addr_data_o_r <= 8'h00;
      muxed_addr_data_oe_r <= 1'b1;
      ale_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      cs_late_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      slow_r <= slow_nxt;
      rsp_valid_r <= 1'b0;
      if (take)
      begin
        op_r <= cmd_op;
        data_r <= cmd_data;
        if (is_bus_op(cmd_op))
          muxed_addr_data_o_r <= cmd_addr_lo;
        if (is_ext_op(cmd_op))
          upper_addr_r <= cmd_addr_hi;
        if (cmd_op == `OP_AUX_READ)
        begin
          rsp_valid_r <= 1'b1;
          rsp_data_r <= {6'h00, lvl_irq, lvl_zero};
        end
      end
      ale_r <= (state_nxt == ST_ALE);
      wr_n_r <= ~(state_nxt == ST_STROBE && is_write);
      rd_n_r <= ~(state_nxt == ST_STROBE && !is_write);
      if (state_r == ST_ALE && state_nxt != ST_ALE)
      begin
        if (is_write)
          muxed_addr_data_o_r <= data_r;
        else
          muxed_addr_data_oe_r <= 1'b0;
      end
      if (state_r == ST_CSEND)
        muxed_addr_data_oe_r <= 1'b1;
      if (state_r == ST_STROBE && state_nxt == ST_CSEND && !is_write)
      begin
        rsp_valid_r <= 1'b1;
        rsp_data_r <= muxed_addr_data_i;
      end
      cs_late_r <= ~(state_nxt == ST_SETUP || state_nxt == ST_STROBE || state_nxt == ST_CSEND);
    end
  end

  // Select falls half a clock after the latch ends and rises half a clock after the strobe
  always @(negedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cs_n_r <= 1'b1;
    else
      cs_n_r <= ~((state_r == ST_SETUP) || (state_r == ST_STROBE) ||
                  (state_r != ST_CSEND && !cs_late_r));
  end
endmodule // mcu_host_bus

/* File: mcu_host_bus_checker.sv */
`timescale 1ns/100ps
// Watches strobe order and phase widths on the host bus
module mcu_host_bus_checker (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Observed outputs
  input wire cmd_ready,
  input wire [7:0] muxed_addr_data_o_r,
  input wire muxed_addr_data_oe_r,
  input wire ale_r,
  input wire cs_n_r,
  input wire rd_n_r,
  input wire wr_n_r,
  input wire bus_clock_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Clock pin, select and idle levels
  clk_pin_a: assert property (bus_clock_out == clk) else $error("clock pin");
  strobe_sel_a: assert property (!(rd_n_r && wr_n_r) |-> !cs_n_r)
    else $error("strobe without select");
  idle_quiet_a: assert property (cmd_ready |-> rd_n_r && wr_n_r && !ale_r)
    else $error("strobe in idle");
  // Write data driven and steady through the strobe and its rising edge
  wr_data_a: assert property ((!wr_n_r || $rose(wr_n_r)) |->
    muxed_addr_data_oe_r && $stable(muxed_addr_data_o_r)) else $error("write data");
  rd_float_a: assert property (!rd_n_r |-> !muxed_addr_data_oe_r)
    else $error("bus driven in read");
  // Strobe and latch widths, normal or stretched
  wr_len_a: assert property ($fell(wr_n_r) |=>
    wr_n_r or (!wr_n_r [*5] ##1 wr_n_r)) else $error("write width");
  rd_len_a: assert property ($fell(rd_n_r) |=>
    rd_n_r or (!rd_n_r [*4] ##1 rd_n_r)) else $error("read width");
  ale_len_a: assert property ($rose(ale_r) |=>
    !ale_r or (ale_r ##1 !ale_r)) else $error("latch width");
endmodule // mcu_host_bus_checker

bind mcu_host_bus mcu_host_bus_checker chk_u (.clk, .sys_rst, .cmd_ready,
  .muxed_addr_data_o_r, .muxed_addr_data_oe_r, .ale_r, .cs_n_r, .rd_n_r, .wr_n_r,
  .bus_clock_out);

/* File: periph_model.sv */
`timescale 1ns/100ps
// Memory-mapped peripheral on the muxed bus
module periph_model (
  // Bus from the host
  input wire clk,
  input wire [7:0] ad_out,
  input wire [7:0] upper,
  input wire ale,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire slow,
  // Answers
  output wire [7:0] ad_drive,
  output wire rdy
);
  reg [7:0] mem [0:65535];
  reg [15:0] addr_r;
  // Address register loads on each rising clock edge while the pulse is high; write while selected
  always @(posedge clk)
  begin
    if (ale)
      addr_r <= {upper, ad_out};
    if (!cs_n && !wr_n)
      mem[addr_r] <= ad_out;
  end
  // Drive only in a selected read; the pull-up shows otherwise
  assign ad_drive = (!cs_n && !rd_n) ? mem[addr_r] : 8'hff;
  assign rdy = !slow;
endmodule // periph_model

/* File: mcu_host_bus_tb_top.sv */
`timescale 1ns/100ps
`include "mcu_bus_defs.vh"
module mcu_host_bus_tb_top;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg cmd_valid = 1'b0;
  reg [2:0] cmd_op = 3'h0;
  reg [7:0] c_hi = 8'h00, c_lo = 8'h00, c_d = 8'h00, h, a, d, r;
  reg pull_opt = 1'b0, suspend = 1'b0, slow = 1'b0, irq = 1'b1;
  wire cmd_ready, rsp_v, ad_oe, z_o, z_oe, q_o, q_oe, q_pl, rdy, ale, cs_n, rd_n, wr_n;
  wire z_pl, m_pl;
  wire [7:0] rsp_d, ad_o, ad_q, upper;
  integer err_total = 0, checks_done = 0, cyc = 0, i, n;
  always #20 clk = ~clk;
  mcu_host_bus dut_u (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr_hi(c_hi), .cmd_addr_lo(c_lo),
    .cmd_data(c_d), .rsp_valid_r(rsp_v), .rsp_data_r(rsp_d), .pull_opt(pull_opt),
    .suspend(suspend), .muxed_addr_data_i(ad_oe ? ad_o : ad_q),
    .muxed_addr_data_o_r(ad_o), .muxed_addr_data_oe_r(ad_oe),
    .muxed_addr_data_pull_low(m_pl), .upper_addr_r(upper), .ale_r(ale), .cs_n_r(cs_n),
    .rd_n_r(rd_n), .wr_n_r(wr_n), .peripheral_ready_in(rdy), .bus_clock_out(),
    .aux_line_zero_i(z_oe ? z_o : 1'b1), .aux_line_zero_o(z_o), .aux_line_zero_oe(z_oe),
    .aux_line_zero_pull_low(z_pl), .aux_line_irq_wait_i(q_oe ? q_o : irq),
    .aux_line_irq_wait_o(q_o), .aux_line_irq_wait_oe(q_oe),
    .aux_line_irq_wait_pull_low(q_pl));
  periph_model per_u (.clk(clk), .ad_out(ad_o), .upper(upper), .ale(ale), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .slow(slow), .ad_drive(ad_q), .rdy(rdy));
  // Compare and count
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("FAIL %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Offer one command and drop the request after it is taken
  task cmd(input [2:0] op, input [7:0] hi, input [7:0] lo, input [7:0] dt);
    begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      c_hi = hi;
      c_lo = lo;
      c_d = dt;
      while (!cmd_ready)
        @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
    end
  endtask
  // Wait a bounded time for the result pulse
  task get;
    begin
      i = 0;
      while (rsp_v !== 1'b1 && i < 40)
      begin
        @(negedge clk);
        i = i + 1;
      end
      chk({7'h0, rsp_v}, 8'h01);
      r = rsp_d;
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Cut a hang short
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  // Main sequence
  initial
  begin
    i = $urandom(59);
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    // Extended and plain accesses, random stretch
    for (n = 0; n < 8; n = n + 1)
    begin
      h = $urandom;
      a = $urandom;
      d = $urandom;
      slow = $urandom;
      cmd(`OP_WRITE_EXT, h, a, d);
      cmd(`OP_READ, ~h, a, 8'h00);
      get;
      chk(r, d);
      chk(upper, h);
      cmd(`OP_WRITE, ~h, a ^ 8'h01, ~d);
      cmd(`OP_READ_EXT, h, a ^ 8'h01, 8'h00);
      get;
      chk(r, ~d);
    end
    $display("test 1 done");
    // Drive the first aux line, keep the wait line an input
    for (n = 0; n < 4; n = n + 1)
    begin
      d = $urandom;
      irq = d[1];
      cmd(`OP_AUX_SET, 8'h00, 8'h01, d);
      cmd(`OP_AUX_READ, 8'h00, 8'h00, 8'h00);
      get;
      chk(r, {6'h0, d[1], d[0]});
      chk({6'h0, z_oe, q_oe}, 8'h02);
    end
    $display("test 2 done");
    // Stall on the wait line, then carry on
    for (n = 0; n < 2; n = n + 1)
    begin
      // Opcode 6 stalls on a low line, opcode 7 on a high one
      irq = n[0];
      cmd(n[0] ? `OP_WAIT_LOW : `OP_WAIT_HIGH, 8'h00, 8'h00, 8'h00);
      repeat (4) @(negedge clk);
      chk({7'h0, cmd_ready}, 8'h00);
      irq = ~n[0];
      cmd(`OP_AUX_READ, 8'h00, 8'h00, 8'h00);
      get;
      chk({7'h0, r[1]}, {7'h0, ~n[0]});
    end
    $display("test 3 done");
    // Weak pull on input lines in suspend, none on the driven bus
    cmd(`OP_AUX_SET, 8'h00, 8'h00, 8'h00);
    for (n = 0; n < 4; n = n + 1)
    begin
      pull_opt = n[0];
      suspend = n[1];
      repeat (2) @(negedge clk);
      chk({7'h0, q_pl}, {7'h0, n[0] & n[1]});
      chk({7'h0, z_pl}, {7'h0, n[0] & n[1]});
      chk({7'h0, m_pl}, 8'h00);
    end
    $display("test 4 done");
    report_and_stop;
  end
endmodule // mcu_host_bus_tb_top
